/* File: hw/usirq_regs.sv */
// usart interrupt enable, flag, line status and sync-busy registers
`timescale 1ns/10ps
`include "usirq_cfg.svh"

// Notes on behaviour
// [R1] writing one to an enable-set bit sets that interrupt enable
// [R2] enable-set and enable-clear read the same enable bits
// [R3] error flag sets on any line error; write one clears
// [R4] break flag sets on break in auto-baud format; write one clears
// [R5] handshake-change flag sets on any clear-to-send level change
// [R6] receive-start flag sets on start condition with detection enabled
// [R7] receive-complete is high while unread data; read or rx-off clears
// [R8] transmit-complete sets when frame left, nothing pending; clears
// [R9] data-empty is high while transmit data register is empty
// [R10] transmitter-empty status always reads zero
// [R11] collision status sets with detection on; write one or rx-off clears
// [R12] inconsistent sync sets in auto-baud when sync field not pattern
// [R13] status shows clear-to-send level when flow control is on
// [R14] overflow sets on start bit with buffer and shifter full
// [R15] framing error sets when first stop bit samples zero
// [R16] parity error sets on mismatch when format enables parity
// [R17] overflow, framing, parity describe the next character to read; the code keeps them until written one or rx-off
// [R18] second control write while enabled is busy; rewrite errors
// [R19] unit-enable write raises enable-busy until crossed
// [R20] software-reset write raises reset-busy until reset completes
// [R21] writing one to an enable-clear bit clears that enable
// [R22] data read returns oldest character and clears receive-complete
// [R23] interrupt request is high while any enabled flag is high
module usirq_regs #(
  parameter int CORE_DIV = `CORE_DIV,
  parameter int SYNC_TICKS = `SYNC_TICKS
) (
  // clock and reset
  input logic clk_i,
  input logic rst_n_i,
  // register port
  input usirq_pkg::usirq_req_s req_i,
  output usirq_pkg::usirq_rsp_s rsp_o,
  // receiver and line events
  input usirq_pkg::usirq_rx_evt_s evt_i,
  input logic cts_i,
  // transmitter
  input logic tx_take_i,
  input logic tx_done_i,
  output logic [8:0] tx_data_o,
  output logic tx_valid_o,
  // controls toward the frame engine
  output usirq_pkg::usirq_ctl1_s ctl1_o,
  output usirq_pkg::usirq_ctl2_s ctl2_o,
  // interrupt
  output logic irq_o
);
  import usirq_pkg::*;

  localparam int DW = $clog2(CORE_DIV + 1);

  function automatic logic [7:0] sticky8(input logic [7:0] q,
                                         input logic [7:0] set,
                                         input logic [7:0] clr);
    // set wins over a clear in the same cycle
    return set | (q & ~clr);
  endfunction

  usirq_ctl1_s ctl1_ff, nxt_ctl1;
  usirq_ctl2_s ctl2_ff, nxt_ctl2;
  usirq_rsp_s rsp_ff, nxt_rsp;
  logic [7:0] en_ff, nxt_en;
  logic [7:0] flg_ff, nxt_flg;
  logic [7:0] st_ff, nxt_st;
  logic [8:0] rx_data_ff, nxt_rx_data;
  logic [8:0] tx_data_ff, nxt_tx_data;
  logic rx_full_ff, nxt_rx_full;
  logic tx_full_ff, nxt_tx_full;
  logic cts_prev_ff;
  logic irq_ff, nxt_irq;
  logic [DW-1:0] div_ff, nxt_div;
  logic ctl2_busy, en_busy, sw_busy, sw_done;
  logic [31:0] rd_ctl1, rd_ctl2;

  // address decode
  wire wr = req_i.valid && req_i.write;
  wire rd = req_i.valid && !req_i.write;
  wire [7:0] wd = req_i.wdata[7:0];
  wire hit_ctl1 = (req_i.addr == `OFF_CTL1);
  wire hit_ctl2 = (req_i.addr == `OFF_CTL2);
  wire hit_enclr = (req_i.addr == `OFF_ENCLR);
  wire hit_enset = (req_i.addr == `OFF_ENSET);
  wire hit_flags = (req_i.addr == `OFF_FLAGS);
  wire hit_status = (req_i.addr == `OFF_STATUS);
  wire hit_sync = (req_i.addr == `OFF_SYNC);
  wire hit_data = (req_i.addr == `OFF_DATA);

  // core rate tick; the sync logic only advances on it
  wire core_tick = (div_ff == DW'(CORE_DIV - 1));
  assign nxt_div = core_tick ? '0 : div_ff + DW'(1);

  // writes and their side effects
  wire srst = sw_done;
  wire ctl2_err = wr && hit_ctl2 && ctl2_busy;                      // [R18]
  wire w_ctl2 = wr && hit_ctl2 && !ctl2_busy && !sw_busy;
  wire w_ctl1 = wr && hit_ctl1 && !sw_busy;
  wire w_enset = wr && hit_enset;
  wire w_enclr = wr && hit_enclr;
  wire w_flags = wr && hit_flags;
  wire w_status = wr && hit_status;
  wire wr_data = wr && hit_data && !tx_full_ff;
  wire rd_data = rd && hit_data;

  // frame format and receiver state
  wire autobaud = (ctl1_ff.frame_format == `FRAME_FORMAT_AUTOBAUD) ||
                  (ctl1_ff.frame_format == `FRAME_FORMAT_AB_PARITY);
  wire parity_on = (ctl1_ff.frame_format == `FRAME_FORMAT_PARITY) ||
                   (ctl1_ff.frame_format == `FRAME_FORMAT_AB_PARITY);
  wire rx_off = !ctl1_ff.enable || !ctl2_ff.rx_en;

  // engine events
  wire e_collide = ctl2_ff.collision_status_det_en && evt_i.collide;            // [R11]
  wire e_bad_sync = autobaud && evt_i.sync_valid &&
                    (evt_i.sync_byte != `SYNC_PATTERN);             // [R12]
  wire e_ovf = evt_i.start_bit && rx_full_ff && evt_i.shift_full;   // [R14]
  wire e_frame = evt_i.char_valid && !evt_i.stop_bit;          // [R15] [R17]
  wire e_parity = evt_i.char_valid && parity_on && evt_i.parity_bad; // [R16]
  wire e_err = !rx_off &&
               (e_collide || e_bad_sync || e_ovf || e_frame || e_parity);
  wire e_brk = autobaud && evt_i.break_rx;                          // [R4]
  wire e_cts = (cts_i != cts_prev_ff);                              // [R5]
  wire e_rx_start = ctl2_ff.sof_det_en && evt_i.start_cond;         // [R6]
  wire e_tx_done = tx_done_i && !tx_full_ff && !wr_data;            // [R8]
  wire cts_lvl = cts_i && ctl1_ff.flow_en;                          // [R13]

  // interrupt flags; receive-complete and data-empty are live views
  wire [7:0] set_flg = {e_err, 1'b0, e_brk, e_cts, e_rx_start,
                        1'b0, e_tx_done, 1'b0};                     // [R3]
  wire [7:0] clr_flg = (w_flags ? wd : 8'h00) |
                       {6'h00, wr_data, 1'b0};                      // [R8]
  assign nxt_flg = srst ? `RST_FLG :
                   sticky8(flg_ff, set_flg, clr_flg) & `FLG_STICKY;
  wire [7:0] flag_vec = flg_ff |
                        {5'h00, rx_full_ff, 1'b0, !tx_full_ff};     // [R9]
  wire [7:0] nxt_flag_vec = nxt_flg |
                            {5'h00, nxt_rx_full, 1'b0, !nxt_tx_full};

  // line status; a disabled receiver reports nothing but the clear-to-send level
  wire [7:0] set_st = {2'b00, e_collide, e_bad_sync, 1'b0, e_ovf,
                       e_frame, e_parity} & {8{!rx_off}};
  wire [7:0] clr_st = (w_status ? wd : 8'h00) | {8{rx_off}};     // [R11]
  assign nxt_st = srst ? `RST_ST :
                  sticky8(st_ff, set_st, clr_st) & `ST_STICKY;
  // transmitter-empty bit is not stored, so it always reads zero
  wire [7:0] st_vec = st_ff | {4'h0, cts_lvl, 3'h0};                // [R10]

  // interrupt enables, one shared set of bits
  wire [7:0] set_en = w_enset ? wd : 8'h00;                         // [R1]
  wire [7:0] clr_en = w_enclr ? wd : 8'h00;                         // [R21]
  assign nxt_en = srst ? `RST_EN : ((en_ff | set_en) & ~clr_en) & `IRQ_MASK;
  assign nxt_irq = |(nxt_flag_vec & nxt_en);                        // [R23]

  // one-deep receive holding and transmit data registers
  wire rx_load = evt_i.char_valid && (!rx_full_ff || rd_data);
  assign nxt_rx_data = rx_load ? evt_i.char_data : rx_data_ff;
  assign nxt_rx_full = !srst && !rx_off &&
                       (evt_i.char_valid || (rx_full_ff && !rd_data)); // [R7]
  // data written while the register is full is dropped
  assign nxt_tx_data = wr_data ? req_i.wdata[8:0] : tx_data_ff;
  assign nxt_tx_full = !srst &&
                       (wr_data || (tx_full_ff && !tx_take_i));     // [R9]

  // control registers
  always_comb begin
    nxt_ctl1 = ctl1_ff;
    nxt_ctl2 = ctl2_ff;
    if (srst) begin
      nxt_ctl1 = '0;
      nxt_ctl2 = '0;
    end else begin
      if (w_ctl1) begin
        nxt_ctl1.enable = req_i.wdata[`CA_ENABLE];
        nxt_ctl1.flow_en = req_i.wdata[`CA_FLOW];
        nxt_ctl1.frame_format = req_i.wdata[`CA_FRAME_FORMAT_LSB +: 4];
      end
      if (w_ctl2) begin
        nxt_ctl2.collision_status_det_en = req_i.wdata[`CB_COLLISION_STATUS_DET];
        nxt_ctl2.sof_det_en = req_i.wdata[`CB_SOF_DET];
        nxt_ctl2.rx_en = req_i.wdata[`CB_RXEN];
      end
    end
  end

  always_comb begin
    rd_ctl1 = 32'h0000_0000;
    rd_ctl1[`CA_SOFT_RST] = sw_busy;
    rd_ctl1[`CA_ENABLE] = ctl1_ff.enable;
    rd_ctl1[`CA_FLOW] = ctl1_ff.flow_en;
    rd_ctl1[`CA_FRAME_FORMAT_LSB +: 4] = ctl1_ff.frame_format;
    rd_ctl2 = 32'h0000_0000;
    rd_ctl2[`CB_COLLISION_STATUS_DET] = ctl2_ff.collision_status_det_en;
    rd_ctl2[`CB_SOF_DET] = ctl2_ff.sof_det_en;
    rd_ctl2[`CB_RXEN] = ctl2_ff.rx_en;
  end

  // read selection; unmapped offsets read zero without error
  wire [31:0] rd_mux =
    hit_ctl1 ? rd_ctl1 :
    hit_ctl2 ? rd_ctl2 :
    (hit_enset || hit_enclr) ? {24'h0, en_ff} :                     // [R2]
    hit_flags ? {24'h0, flag_vec} :
    hit_status ? {24'h0, st_vec} :
    hit_sync ? {29'h0, ctl2_busy, en_busy, sw_busy} :
    hit_data ? {23'h0, rx_data_ff} :                                // [R22]
    32'h0000_0000;
  assign nxt_rsp.ack = req_i.valid;
  assign nxt_rsp.err = ctl2_err;                                    // [R18]
  assign nxt_rsp.rdata = rd ? rd_mux : 32'h0000_0000;

  // crossings into the core domain
  usirq_sync_busy #(.SYNC_TICKS(SYNC_TICKS)) u_sync_ctl2 (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i(core_tick),
    .start_i(w_ctl2 && ctl1_ff.enable),                             // [R18]
    .busy_o(ctl2_busy), .done_o());
  usirq_sync_busy #(.SYNC_TICKS(SYNC_TICKS)) u_sync_en (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i(core_tick),
    .start_i(w_ctl1),                                               // [R19]
    .busy_o(en_busy), .done_o());
  usirq_sync_busy #(.SYNC_TICKS(SYNC_TICKS)) u_sync_sw (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i(core_tick),
    .start_i(w_ctl1 && req_i.wdata[`CA_SOFT_RST]),                  // [R20]
    .busy_o(sw_busy), .done_o(sw_done));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl1_ff <= '0;
      ctl2_ff <= '0;
      rsp_ff <= '0;
      en_ff <= `RST_EN;
      flg_ff <= `RST_FLG;
      st_ff <= `RST_ST;
      rx_data_ff <= 9'h000;
      tx_data_ff <= 9'h000;
      rx_full_ff <= 1'b0;
      tx_full_ff <= 1'b0;
      cts_prev_ff <= 1'b0;
      irq_ff <= 1'b0;
      div_ff <= '0;
    end else begin
      ctl1_ff <= nxt_ctl1;
      ctl2_ff <= nxt_ctl2;
      rsp_ff <= nxt_rsp;
      en_ff <= nxt_en;
      flg_ff <= nxt_flg;
      st_ff <= nxt_st;
      rx_data_ff <= nxt_rx_data;
      tx_data_ff <= nxt_tx_data;
      rx_full_ff <= nxt_rx_full;
      tx_full_ff <= nxt_tx_full;
      cts_prev_ff <= cts_i;
      irq_ff <= nxt_irq;
      div_ff <= nxt_div;
    end
  end

  assign rsp_o = rsp_ff;
  assign irq_o = irq_ff;
  assign tx_data_o = tx_data_ff;
  assign tx_valid_o = tx_full_ff;
  assign ctl1_o = ctl1_ff;
  assign ctl2_o = ctl2_ff;

  // checks
  localparam int SYNC_MAX = 64;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ctl2_start;
    w_ctl2 && ctl1_ff.enable;
  endsequence
  sequence s_ctl2_hold;
    ctl2_busy [*2];
  endsequence

  a_enset_sets: assert property (w_enset && !srst |=> // [R1]
    ((en_ff & $past(set_en) & `IRQ_MASK) == ($past(set_en) & `IRQ_MASK)))
    else $error("enable-set write did not set enables");
  a_enclr_reads: assert property (rd && hit_enclr |=> // [R2]
    rsp_ff.rdata[7:0] == $past(en_ff))
    else $error("enable-clear read differs from enables");
  a_enclr_clears: assert property (w_enclr && !srst |=> // [R21]
    (en_ff & $past(clr_en)) == 8'h00)
    else $error("enable-clear write left an enable set");
  a_err_flag_set: assert property (e_err && !srst |=> // [R3]
    flg_ff[`FLG_ERR])
    else $error("line error did not raise error flag");
  a_brk_flag_set: assert property (e_brk && !srst |=> // [R4]
    flg_ff[`FLG_BRK])
    else $error("break not flagged");
  a_cts_change_set: assert property ($changed(cts_i) && !srst |=> // [R5]
    flg_ff[`FLG_CTS])
    else $error("clear-to-send change not flagged");
  a_rxs_flag_set: assert property (e_rx_start && !srst |=> // [R6]
    flg_ff[`FLG_RX_START])
    else $error("receive start not flagged");
  a_rxc_read_clear: assert property (rd_data && !evt_i.char_valid |=> // [R22]
    !flag_vec[`FLG_RX_DONE])
    else $error("data read did not clear receive-complete");
  a_txc_write_clear: assert property (wr_data |=> // [R8]
    !flg_ff[`FLG_TX_DONE] && !flag_vec[`FLG_TX_EMPTY] && tx_valid_o)
    else $error("data write did not clear tx flags");
  a_txe_reads_zero: assert property (rd && hit_status |=> // [R10]
    !rsp_ff.rdata[`ST_TX_IDLE])
    else $error("transmitter-empty read as one");
  a_rxoff_clears: assert property (rx_off |=> st_ff == 8'h00) // [R11]
    else $error("status kept with receiver disabled");
  a_cts_level_read: assert property (rd && hit_status |=> // [R13]
    rsp_ff.rdata[`ST_CTS] == $past(cts_lvl))
    else $error("clear-to-send level read wrong");
  a_ovf_set: assert property (e_ovf && !rx_off && !srst |=> // [R14]
    st_ff[`ST_OVF] && flg_ff[`FLG_ERR])
    else $error("overflow not reported");
  a_ctl2_busy_hold: assert property (s_ctl2_start |=> s_ctl2_hold) // [R18]
    else $error("second control write not busy");
  a_ctl2_busy_err: assert property (ctl2_err |=> // [R18]
    rsp_ff.err && rsp_ff.ack && (ctl2_ff == $past(ctl2_ff)))
    else $error("busy rewrite not refused");
  a_en_busy_ends: assert property (w_ctl1 |=> // [R19]
    en_busy ##[1:SYNC_MAX] !en_busy)
    else $error("enable-busy did not rise and fall");
  a_software_reset_done: assert property (sw_done |=> // [R20]
    en_ff == 8'h00 && flg_ff == 8'h00 && !tx_full_ff && !sw_busy)
    else $error("software reset left state behind");
  a_irq_match: assert property (irq_o == |(flag_vec & en_ff)) // [R23]
    else $error("interrupt request does not match flags");

endmodule

/* File: hw/usirq_sync_busy.sv */
// busy tracker for one write crossing into the core tick domain
`timescale 1ns/10ps
`include "usirq_cfg.svh"

module usirq_sync_busy #(
  parameter int SYNC_TICKS = `SYNC_TICKS
) (
  // clock and reset
  input logic clk_i,
  input logic rst_n_i,
  // core rate enable and start
  input logic tick_i,
  input logic start_i,
  // state
  output logic busy_o,
  output logic done_o
);
  import usirq_pkg::*;

  localparam int CW = $clog2(SYNC_TICKS + 1);

  usirq_sync_e state_ff;
  usirq_sync_e nxt_state;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;

  wire last_tick = tick_i && (cnt_ff == CW'(SYNC_TICKS - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      USIRQ_IDLE: begin
        // a second start while busy is absorbed by the running crossing
        if (start_i) begin
          nxt_state = USIRQ_COUNT;
          nxt_cnt = '0;
        end
      end
      USIRQ_COUNT: begin
        if (last_tick) begin
          nxt_state = USIRQ_DONE;
        end else if (tick_i) begin
          nxt_cnt = cnt_ff + CW'(1);
        end
      end
      USIRQ_DONE: begin
        nxt_state = USIRQ_IDLE;
      end
      default: begin
        nxt_state = USIRQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= USIRQ_IDLE;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy_o = (state_ff != USIRQ_IDLE);
  assign done_o = (state_ff == USIRQ_DONE);

endmodule

/* File: pkg/usirq_cfg.svh */
// offsets, field positions, reset values and timing counts of the block
`ifndef USIRQ_CFG_SVH
`define USIRQ_CFG_SVH

// register offsets (byte addresses)
`define OFF_CTL1 8'h00
`define OFF_CTL2 8'h04
`define OFF_ENCLR 8'h14
`define OFF_ENSET 8'h16
`define OFF_FLAGS 8'h18
`define OFF_STATUS 8'h1a
`define OFF_SYNC 8'h1c
`define OFF_DATA 8'h28

// first control register fields
`define CA_SOFT_RST 0
`define CA_ENABLE 1
`define CA_FLOW 16
`define CA_FRAME_FORMAT_LSB 24

// second control register fields
`define CB_COLLISION_STATUS_DET 8
`define CB_SOF_DET 9
`define CB_RXEN 17

// interrupt flag and enable fields
`define FLG_ERR 7
`define FLG_BRK 5
`define FLG_CTS 4
`define FLG_RX_START 3
`define FLG_RX_DONE 2
`define FLG_TX_DONE 1
`define FLG_TX_EMPTY 0
`define IRQ_MASK 8'hbf
`define FLG_STICKY 8'hba

// line status fields: errors, clear-to-send level and transmitter-empty
`define ST_TX_IDLE 6
`define ST_COLLIDE 5
`define ST_BAD_SYNC 4
`define ST_CTS 3
`define ST_OVF 2
`define ST_FRAME 1
`define ST_PARITY 0
`define ST_STICKY 8'h37

// synchronization busy fields
`define SB_CTL2 2
`define SB_EN 1
`define SB_SW 0

// frame format codes and sync pattern
`define FRAME_FORMAT_PARITY 4'h1
`define FRAME_FORMAT_AUTOBAUD 4'h4
`define FRAME_FORMAT_AB_PARITY 4'h5
`define SYNC_PATTERN 8'h55

// reset values
`define RST_EN 8'h00
`define RST_FLG 8'h00
`define RST_ST 8'h00

// core domain tick divider and sync length in core ticks
`define CORE_DIV 4
`define SYNC_TICKS 3

`endif

/* File: pkg/usirq_pkg.sv */
// types shared by the usart interrupt, status and sync-busy logic
package usirq_pkg;

  typedef enum logic [1:0] {
    USIRQ_IDLE = 2'b00,
    USIRQ_COUNT = 2'b01,
    USIRQ_DONE = 2'b11
  } usirq_sync_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } usirq_req_s;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } usirq_rsp_s;

  typedef struct packed {
    logic start_bit;
    logic shift_full;
    logic char_valid;
    logic [8:0] char_data;
    logic stop_bit;
    logic parity_bad;
    logic break_rx;
    logic collide;
    logic sync_valid;
    logic [7:0] sync_byte;
    logic start_cond;
  } usirq_rx_evt_s;

  typedef struct packed {
    logic [3:0] frame_format;
    logic flow_en;
    logic enable;
  } usirq_ctl1_s;

  typedef struct packed {
    logic rx_en;
    logic sof_det_en;
    logic collision_status_det_en;
  } usirq_ctl2_s;

endpackage

/* File: testbench/tb.sv */
// self-checking bench for the usart interrupt, status and sync registers
`timescale 1ns/10ps
`include "usirq_cfg.svh"
module tb;
  import usirq_pkg::*;
  logic clk_i, rst_n_i, cts, tx_take, tx_done, tx_valid, irq, er;
  usirq_req_s req_i;
  usirq_rsp_s rsp_o;
  usirq_rx_evt_s evt;
  usirq_ctl1_s ctl1;
  usirq_ctl2_s ctl2;
  logic [8:0] tx_data;
  logic [31:0] rd;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  usirq_regs #(.CORE_DIV(4), .SYNC_TICKS(3)) dut_u (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .req_i(req_i), .rsp_o(rsp_o), .evt_i(evt),
    .cts_i(cts), .tx_take_i(tx_take), .tx_done_i(tx_done),
    .tx_data_o(tx_data), .tx_valid_o(tx_valid), .ctl1_o(ctl1),
    .ctl2_o(ctl2), .irq_o(irq));
  usirq_engine_model eng_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .evt_o(evt), .cts_o(cts),
    .tx_take_o(tx_take), .tx_done_o(tx_done));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // budget is generous; the whole run takes well under two thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("unexpected at %0t: run did not finish", $time);
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // request held for its taking edge only, answer read 1 ns after that edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    req_i <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge clk_i);
    req_i.valid <= 1'b0;
    #1;
    chk(rsp_o.ack, 1'b1);
    rd = rsp_o.rdata;
    er = rsp_o.err;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 40; i++) begin
      bus(1'b0, `OFF_SYNC, 32'h0);
      if (rd[2:0] === 3'h0) break;
    end
    chk(rd, 32'h0);
  endtask
  task automatic t_reset();
    rdchk(`OFF_ENSET, 32'hff, 32'h0);
    rdchk(`OFF_ENCLR, 32'hff, 32'h0);
    rdchk(`OFF_STATUS, 32'hffff, 32'h0);
    rdchk(`OFF_SYNC, 32'hffffffff, 32'h0);
    rdchk(8'h30, 32'hffffffff, 32'h0);
    chk(er, 1'b0);
  endtask
  task automatic t_enable();
    bus(1'b1, `OFF_ENSET, 32'hff);
    rdchk(`OFF_ENSET, 32'hff, 32'hbf);
    rdchk(`OFF_ENCLR, 32'hff, 32'hbf);
    bus(1'b1, `OFF_ENCLR, 32'h41);
    bus(1'b1, `OFF_ENSET, 32'h00);
    rdchk(`OFF_ENSET, 32'hff, 32'hbe);
    bus(1'b1, `OFF_ENCLR, 32'hff);
    rdchk(`OFF_ENCLR, 32'hff, 32'h00);
  endtask
  task automatic t_config();
    bus(1'b1, `OFF_CTL1, 32'h05010002);
    rdchk(`OFF_SYNC, 32'h2, 32'h2);
    wait_idle();
    bus(1'b1, `OFF_CTL2, 32'h00020300);
    bus(1'b1, `OFF_CTL2, 32'h00020000);
    chk(er, 1'b1);
    rdchk(`OFF_SYNC, 32'h4, 32'h4);
    wait_idle();
    chk({ctl1, ctl2}, {4'h5, 1'b1, 1'b1, 3'b111});
    bus(1'b1, `OFF_CTL2, 32'h00020300);
    chk(er, 1'b0);
    wait_idle();
  endtask
  task automatic t_rx();
    usirq_rx_evt_s e;
    e = '0;
    e.char_valid = 1'b1;
    e.char_data = 9'h1a3;
    e.stop_bit = 1'b1;
    eng_u.pulse(e);
    rdchk(`OFF_FLAGS, 32'hfe, 32'h04);
    rdchk(`OFF_STATUS, 32'hfff7, 32'h0);
    rdchk(`OFF_DATA, 32'h1ff, 32'h1a3);
    rdchk(`OFF_FLAGS, 32'hfe, 32'h00);
    e.char_data = 9'h05a;
    e.stop_bit = 1'b0;
    e.parity_bad = 1'b1;
    eng_u.pulse(e);
    rdchk(`OFF_STATUS, 32'hfff7, 32'h03);
    rdchk(`OFF_FLAGS, 32'hfe, 32'h84);
    rdchk(`OFF_DATA, 32'h1ff, 32'h05a);
    bus(1'b1, `OFF_FLAGS, 32'h04);
    bus(1'b1, `OFF_STATUS, 32'h0040);
    rdchk(`OFF_STATUS, 32'hfff7, 32'h03);
    bus(1'b1, `OFF_STATUS, 32'h0003);
    rdchk(`OFF_STATUS, 32'hfff7, 32'h0);
    rdchk(`OFF_FLAGS, 32'hfe, 32'h80);
    bus(1'b1, `OFF_FLAGS, 32'h80);
    rdchk(`OFF_FLAGS, 32'hfe, 32'h00);
  endtask
  task automatic t_events();
    usirq_rx_evt_s e;
    logic [7:0] fexp [5] = '{8'h20, 8'h08, 8'h80, 8'h80, 8'h00};
    logic [7:0] sexp [5] = '{8'h00, 8'h00, 8'h20, 8'h10, 8'h00};
    int i;
    for (i = 0; i < 5; i++) begin
      e = '0;
      e.break_rx = (i == 0);
      e.start_cond = (i == 1);
      e.collide = (i == 2);
      e.sync_valid = (i >= 3);
      e.sync_byte = (i == 3) ? 8'h12 : `SYNC_PATTERN;
      eng_u.pulse(e);
      rdchk(`OFF_FLAGS, 32'hfe, fexp[i]);
      rdchk(`OFF_STATUS, 32'hfff7, sexp[i]);
      bus(1'b1, `OFF_FLAGS, 32'hff);
      bus(1'b1, `OFF_STATUS, 32'hff);
    end
    e = '0;
    e.char_valid = 1'b1;
    e.stop_bit = 1'b1;
    eng_u.pulse(e);
    e = '0;
    e.start_bit = 1'b1;
    e.shift_full = 1'b1;
    eng_u.pulse(e);
    rdchk(`OFF_STATUS, 32'hfff7, 32'h04);
    rdchk(`OFF_FLAGS, 32'hfe, 32'h84);
    wait_idle();
    bus(1'b1, `OFF_CTL2, 32'h00000300);
    rdchk(`OFF_STATUS, 32'hfff7, 32'h0);
    rdchk(`OFF_FLAGS, 32'h04, 32'h0);
    wait_idle();
    bus(1'b1, `OFF_CTL2, 32'h00020300);
    wait_idle();
    bus(1'b1, `OFF_FLAGS, 32'hff);
    eng_u.set_cts(1'b1);
    rdchk(`OFF_STATUS, 32'h08, 32'h08);
    bus(1'b1, `OFF_STATUS, 32'h08);
    rdchk(`OFF_STATUS, 32'h08, 32'h08);
    rdchk(`OFF_FLAGS, 32'hfe, 32'h10);
    bus(1'b1, `OFF_FLAGS, 32'h10);
    eng_u.set_cts(1'b0);
    rdchk(`OFF_FLAGS, 32'hfe, 32'h10);
    rdchk(`OFF_STATUS, 32'h08, 32'h00);
    bus(1'b1, `OFF_FLAGS, 32'h10);
  endtask
  task automatic t_irq();
    usirq_rx_evt_s e;
    e = '0;
    e.start_cond = 1'b1;
    bus(1'b1, `OFF_ENSET, 32'h08);
    chk(irq, 1'b0);
    eng_u.pulse(e);
    rdchk(`OFF_FLAGS, 32'h08, 32'h08);
    chk(irq, 1'b1);
    bus(1'b1, `OFF_ENCLR, 32'h08);
    rdchk(`OFF_FLAGS, 32'h08, 32'h08);
    chk(irq, 1'b0);
    bus(1'b1, `OFF_FLAGS, 32'h08);
  endtask
  task automatic wait_done();
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      if (tx_done === 1'b1) break;
    end
    chk(tx_done, 1'b1);
  endtask
  task automatic t_tx();
    eng_u.take_wait = 8;
    bus(1'b1, `OFF_DATA, 32'h1a5);
    rdchk(`OFF_FLAGS, 32'h03, 32'h00);
    chk({tx_valid, tx_data}, {1'b1, 9'h1a5});
    bus(1'b1, `OFF_FLAGS, 32'h01);
    rdchk(`OFF_FLAGS, 32'h01, 32'h00);
    wait_done();
    rdchk(`OFF_FLAGS, 32'h03, 32'h03);
    eng_u.take_wait = 0;
    bus(1'b1, `OFF_DATA, 32'h033);
    rdchk(`OFF_FLAGS, 32'h02, 32'h00);
    wait_done();
    rdchk(`OFF_FLAGS, 32'h03, 32'h03);
    bus(1'b1, `OFF_FLAGS, 32'h02);
    rdchk(`OFF_FLAGS, 32'h03, 32'h01);
  endtask
  task automatic t_software_reset();
    bus(1'b1, `OFF_ENSET, 32'h81);
    bus(1'b1, `OFF_CTL1, 32'h00000001);
    rdchk(`OFF_SYNC, 32'h1, 32'h1);
    wait_idle();
    rdchk(`OFF_ENSET, 32'hff, 32'h00);
    chk(ctl1, '0);
  endtask
  initial begin
    rst_n_i = 1'b0;
    req_i = '0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_enable();
    t_config();
    t_rx();
    t_events();
    t_irq();
    t_tx();
    t_software_reset();
    wrap_up();
  end
endmodule

/* File: testbench/usirq_engine_model.sv */
// frame engine stand-in: line events, clear-to-send and transmit pickup
`timescale 1ns/10ps
module usirq_engine_model (
  // clock and reset
  input logic clk_i,
  input logic rst_n_i,
  // transmit side of the register block
  input logic [8:0] tx_data_i,
  input logic tx_valid_i,
  // toward the register block
  output usirq_pkg::usirq_rx_evt_s evt_o,
  output logic cts_o,
  output logic tx_take_o,
  output logic tx_done_o
);
  import usirq_pkg::*;
  int take_wait = 0;
  int wait_cnt = 0;
  int shift_cnt = 0;
  logic [8:0] last_tx = 9'h000;
  initial begin
    evt_o = '0;
    cts_o = 1'b0;
    tx_take_o = 1'b0;
    tx_done_o = 1'b0;
  end
  // one-cycle event; data fields flip afterwards so stale values never match
  task automatic pulse(input usirq_rx_evt_s e);
    usirq_rx_evt_s idle;
    idle = '0;
    idle.char_data = ~e.char_data;
    idle.sync_byte = ~e.sync_byte;
    idle.stop_bit = ~e.stop_bit;
    @(posedge clk_i);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= idle;
  endtask
  task automatic set_cts(input logic v);
    @(posedge clk_i);
    cts_o <= v;
  endtask
  // take_wait lets the bench stall pickup of pending transmit data
  always @(posedge clk_i) begin
    tx_take_o <= 1'b0;
    tx_done_o <= 1'b0;
    if (shift_cnt == 1) tx_done_o <= 1'b1;
    if (shift_cnt > 0) shift_cnt <= shift_cnt - 1;
    if (rst_n_i && tx_valid_i && !tx_take_o && shift_cnt == 0) begin
      if (wait_cnt >= take_wait) begin
        tx_take_o <= 1'b1;
        last_tx <= tx_data_i;
        shift_cnt <= 4;
        wait_cnt <= 0;
      end else wait_cnt <= wait_cnt + 1;
    end
  end
endmodule
